// File: src/tx_fifo_serial_host_port.sv
// Purpose: Four-line serial host port with transmit FIFO loading and register readback.
// Assumes: Serial pins and shutdown are asynchronous and synchronised on CORE_CLK.
// Notes:   Serial clock must be well below CORE_CLK / 4.
`timescale 1ns/1ps
module tx_fifo_serial_host_port
  import txport_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  input  wire logic       SERIAL_SELECT_LOW,
  input  wire logic       SERIAL_CLK,
  input  wire logic       SERIAL_INPUT_LINE,
  input  wire logic       POWER_DOWN_INPUT,
  input  wire logic       POR_EVENT,
  input  wire logic       WAKE_EVENT,
  input  wire logic       LOW_BATTERY,
  input  wire logic       TX_POP,
  output logic            SERIAL_OUTPUT_LINE,
  output logic            INTERRUPT_OUT_LOW,
  output logic [2:0]      GPIO_OUT,
  output logic [7:0]      TX_DATA,
  output logic            TX_VALID
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that the wrapping pointer arithmetic cannot serve.
  if (DEPTH < 4 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("DEPTH must be a power of two from 4 to 64");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers: two flops before anything reads a serial pin or the shutdown pin.
  logic [4:0] s1_q, s1_d, s2_q, s2_d;
  logic       sck_prev_q, sck_prev_d;
  logic       sel_n, sck, serial_input_line, pd, rise, fall, rst;

  always_comb begin
    s1_d       = {SERIAL_SELECT_LOW, SERIAL_CLK, SERIAL_INPUT_LINE, POWER_DOWN_INPUT, 1'b0};
    s2_d       = s1_q;
    sck_prev_d = s2_q[3];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s1_q       <= 5'h10;                    // Idle levels: deselected, clock low.
      s2_q       <= 5'h10;                    // No false clock edge after reset.
      sck_prev_q <= 1'b0;
    end else if (CLK_EN) begin
      s1_q       <= s1_d;
      s2_q       <= s2_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  assign sel_n = s2_q[4];
  assign sck   = s2_q[3];
  assign serial_input_line   = s2_q[2];
  assign pd    = s2_q[1];
  assign rst   = SYS_RST | pd;
  assign rise  = ~sel_n & sck & ~sck_prev_q;
  assign fall  = ~sel_n & ~sck & sck_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial engine, registers and FIFO state.
  spi_phase_t      ph_q, ph_d;
  logic [2:0]      bit_q, bit_d;
  logic [7:0]      sh_q, sh_d, out_q, out_d;
  logic            wr_q, wr_d;
  logic [6:0]      adr_q, adr_d;
  logic [7:0]      hthr_q, hthr_d, lthr_q, lthr_d;
  logic [7:0]      en1_q, en1_d, en2_q, en2_d;
  logic [7:0]      st1_q, st1_d, st2_q, st2_d;
  logic [7:0]      gcfg_q [3];
  logic [7:0]      gcfg_d [3];
  logic [7:0]      mem_q [DEPTH];
  logic [AW:0]     wp_q, wp_d, rp_q, rp_d, cnt;
  logic            mem_we;
  logic [7:0]      byte_in, rdata;
  logic            byte_done, rd_st1, rd_st2;
  logic [7:0]      ev1, ev2;
  logic            tx_v_q, tx_v_d, irq_q, irq_d;
  logic [7:0]      tx_q, tx_d;
  logic [2:0]      gp_q, gp_d;
  logic [5:0]      clkdiv_q, clkdiv_d;
  logic            pop_ok;

  assign cnt       = wp_q - rp_q;
  assign byte_in   = {sh_q[6:0], serial_input_line};
  assign byte_done = rise && (bit_q == 3'd7);

  // Readback mux for registers.
  always_comb begin
    case (adr_q)
      ADDR_IRQ_STATUS_1: rdata = st1_q;
      ADDR_IRQ_STATUS_2: rdata = st2_q;
      ADDR_IRQ_ENABLE_1: rdata = en1_q;
      ADDR_IRQ_ENABLE_2: rdata = en2_q;
      ADDR_GPIO0_CFG:    rdata = gcfg_q[0];
      ADDR_GPIO1_CFG:    rdata = gcfg_q[1];
      ADDR_GPIO2_CFG:    rdata = gcfg_q[2];
      ADDR_TX_HIGH_THR:  rdata = {2'b00, hthr_q[THR_MSB:0]};
      ADDR_TX_LOW_THR:   rdata = {2'b00, lthr_q[THR_MSB:0]};
      default:           rdata = 8'h0_0;
    endcase
  end

  // Next-state of the serial engine, registers and FIFO.
  always_comb begin
    ph_d = ph_q; bit_d = bit_q; sh_d = sh_q; out_d = out_q;
    wr_d = wr_q; adr_d = adr_q; hthr_d = hthr_q; lthr_d = lthr_q;
    en1_d = en1_q; en2_d = en2_q; gcfg_d = gcfg_q;
    wp_d = wp_q; rp_d = rp_q; mem_we = 1'b0; rd_st1 = 1'b0; rd_st2 = 1'b0;
    tx_v_d = tx_v_q; tx_d = tx_q; pop_ok = 1'b0;
    if (sel_n) begin
      ph_d  = SP_CMD;
      bit_d = 3'd0;
      out_d = 8'h0_0;
    end else if (rise) begin
      sh_d  = byte_in;
      bit_d = bit_q + 3'd1;
      if (byte_done) begin
        if (ph_q == SP_CMD) begin
          wr_d  = byte_in[RW_BIT];
          adr_d = byte_in[6:0];
          ph_d  = SP_DATA;
        end else begin
          if (wr_q) begin
            case (adr_q)
              ADDR_IRQ_ENABLE_1: en1_d = byte_in;
              ADDR_IRQ_ENABLE_2: en2_d = byte_in;
              ADDR_GPIO0_CFG:    gcfg_d[0] = byte_in;
              ADDR_GPIO1_CFG:    gcfg_d[1] = byte_in;
              ADDR_GPIO2_CFG:    gcfg_d[2] = byte_in;
              ADDR_TX_HIGH_THR:  hthr_d = {2'b00, byte_in[THR_MSB:0]};
              ADDR_TX_LOW_THR:   lthr_d = {2'b00, byte_in[THR_MSB:0]};
              ADDR_FIFO_DATA: begin
                if (cnt != (AW + 1)'(DEPTH)) begin
                  mem_we = 1'b1;
                  wp_d   = wp_q + 1'b1;
                end
              end
              default: ;
            endcase
          end else begin
            rd_st1 = (adr_q == ADDR_IRQ_STATUS_1);
            rd_st2 = (adr_q == ADDR_IRQ_STATUS_2);
          end
          if (adr_q != ADDR_FIFO_DATA) begin
            adr_d = adr_q + 7'd1;
          end                                   // FIFO address stays fixed.
        end
      end
    end else if (fall && ph_q == SP_DATA) begin
      out_d = (bit_q == 3'd0) ? rdata : {out_q[6:0], 1'b0};
    end
    // One-entry output stage: a stalled sink never loses a word.
    if (!tx_v_q || TX_POP) begin
      pop_ok = (cnt != '0);
      tx_v_d = pop_ok;
      if (pop_ok) begin
        tx_d = mem_q[rp_q[AW-1:0]];
        rp_d = rp_q + 1'b1;
      end
    end
  end

  // Event collection, status bits, interrupt pin and GPIO muxing.
  always_comb begin
    gp_d = 3'b000;
    ev1 = 8'h00;
    ev1[ST_FULL_BIT]     = (cnt == (AW + 1)'(DEPTH));
    ev1[ST_ALMOST_FULL]  = (cnt > (AW + 1)'(hthr_q[THR_MSB:0]));
    ev1[ST_ALMOST_EMPTY] = (cnt <= (AW + 1)'(lthr_q[THR_MSB:0]));
    ev1[ST_EMPTY_BIT]    = (cnt == '0);
    ev2 = {1'b0, POR_EVENT, 1'b0, WAKE_EVENT, LOW_BATTERY, 3'b000};
    st1_d = (rd_st1 ? 8'h0_0 : st1_q) | ev1;    // Set wins over clear.
    st2_d = (rd_st2 ? 8'h0_0 : st2_q) | ev2;
    irq_d = ~(|(st1_d & en1_q) | |(st2_d & en2_q));
    clkdiv_d = clkdiv_q + 6'd1;
    for (int i = 0; i < 3; i++) begin
      case (gcfg_q[i][4:0])
        GP_CLOCK_OUT:         gp_d[i] = clkdiv_q[2];
        GP_POR:               gp_d[i] = POR_EVENT;
        GP_WAKE_TIMER:        gp_d[i] = WAKE_EVENT;
        GP_LOW_BATTERY:       gp_d[i] = LOW_BATTERY;
        GP_FIFO_ALMOST_FULL:  gp_d[i] = ev1[ST_ALMOST_FULL];
        GP_FIFO_ALMOST_EMPTY: gp_d[i] = ev1[ST_ALMOST_EMPTY];
        default:              gp_d[i] = 1'b0;
      endcase
    end
  end

  // Registered state; shutdown acts exactly like reset.
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      ph_q <= SP_CMD; bit_q <= 3'd0; sh_q <= 8'h0_0; out_q <= 8'h0_0;
      wr_q <= 1'b0; adr_q <= 7'h0_0;
      hthr_q <= RST_TX_HIGH_THR; lthr_q <= RST_TX_LOW_THR;
      en1_q <= RST_IRQ_ENABLE; en2_q <= RST_IRQ_ENABLE;
      st1_q <= 8'h0_0; st2_q <= 8'h0_0;
      for (int i = 0; i < 3; i++) gcfg_q[i] <= RST_GPIO_CFG;
      wp_q <= '0; rp_q <= '0; tx_v_q <= 1'b0; tx_q <= 8'h0_0;
      irq_q <= 1'b1; gp_q <= 3'b000; clkdiv_q <= 6'h0_0;
    end else if (CLK_EN) begin
      ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d; out_q <= out_d;
      wr_q <= wr_d; adr_q <= adr_d; hthr_q <= hthr_d; lthr_q <= lthr_d;
      en1_q <= en1_d; en2_q <= en2_d; st1_q <= st1_d; st2_q <= st2_d;
      gcfg_q <= gcfg_d;
      wp_q <= wp_d; rp_q <= rp_d; tx_v_q <= tx_v_d; tx_q <= tx_d;
      irq_q <= irq_d; gp_q <= gp_d; clkdiv_q <= clkdiv_d;
      if (mem_we) mem_q[wp_q[AW-1:0]] <= byte_in;
    end
  end

  assign SERIAL_OUTPUT_LINE = out_q[7];
  assign INTERRUPT_OUT_LOW  = irq_q;
  assign GPIO_OUT           = gp_q;
  assign TX_DATA            = tx_q;
  assign TX_VALID           = tx_v_q;
endmodule : tx_fifo_serial_host_port

// File: src/txport_pkg.sv
// Purpose: Shared constants for the serial host port of the transmitter.
// Assumes: Byte-wide registers, seven-bit register addresses.
// Notes:   Offsets are register addresses on the serial bus.
package txport_pkg;
  localparam logic [6:0] ADDR_IRQ_STATUS_1 = 7'h03;
  localparam logic [6:0] ADDR_IRQ_STATUS_2 = 7'h04;
  localparam logic [6:0] ADDR_IRQ_ENABLE_1 = 7'h05;
  localparam logic [6:0] ADDR_IRQ_ENABLE_2 = 7'h06;
  localparam logic [6:0] ADDR_GPIO0_CFG    = 7'h0B;
  localparam logic [6:0] ADDR_GPIO1_CFG    = 7'h0C;
  localparam logic [6:0] ADDR_GPIO2_CFG    = 7'h0D;
  localparam logic [6:0] ADDR_TX_HIGH_THR  = 7'h7C;
  localparam logic [6:0] ADDR_TX_LOW_THR   = 7'h7D;
  localparam logic [6:0] ADDR_FIFO_DATA    = 7'h7F;
  localparam logic [7:0] RST_TX_HIGH_THR   = 8'h37;
  localparam logic [7:0] RST_TX_LOW_THR    = 8'h04;
  localparam logic [7:0] RST_GPIO_CFG      = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE    = 8'h00;
  localparam int         THR_MSB           = 5;
  localparam int         RW_BIT            = 7;
  localparam int         ST_FULL_BIT       = 7;
  localparam int         ST_EMPTY_BIT      = 6;
  localparam int         ST_ALMOST_FULL    = 5;
  localparam int         ST_ALMOST_EMPTY   = 4;
  localparam logic [4:0] GP_CLOCK_OUT      = 5'h00;
  localparam logic [4:0] GP_POR            = 5'h01;
  localparam logic [4:0] GP_WAKE_TIMER     = 5'h02;
  localparam logic [4:0] GP_LOW_BATTERY    = 5'h03;
  localparam logic [4:0] GP_FIFO_ALMOST_FULL  = 5'h04;
  localparam logic [4:0] GP_FIFO_ALMOST_EMPTY = 5'h05;
  typedef enum logic [1:0] {SP_CMD, SP_DATA} spi_phase_t;
endpackage : txport_pkg

// File: verif/txport_chk.sv
// Purpose: Port checks for the serial host port.
// Assumes: Bound to the top module.
// Notes:   Margins cover the pin synchronisers.
`timescale 1ns/1ps
module txport_chk (
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  input wire logic       CLK_EN,
  input wire logic       SERIAL_SELECT_LOW,
  input wire logic       SERIAL_CLK,
  input wire logic       POWER_DOWN_INPUT,
  input wire logic       TX_POP,
  input wire logic       SERIAL_OUTPUT_LINE,
  input wire logic       INTERRUPT_OUT_LOW,
  input wire logic [2:0] GPIO_OUT,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_VALID
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Each output is tied to the input activity that may move it.
  rst_idle_a: assert property ($fell(SYS_RST) |-> INTERRUPT_OUT_LOW && !TX_VALID
    && GPIO_OUT == 3'h0 && !SERIAL_OUTPUT_LINE) else $error("not idle after reset");
  pd_clear_a: assert property (POWER_DOWN_INPUT [*5] |=> INTERRUPT_OUT_LOW && !TX_VALID)
    else $error("shutdown kept state");
  sdo_idle_a: assert property (SERIAL_SELECT_LOW [*6] |-> !SERIAL_OUTPUT_LINE)
    else $error("output driven while deselected");
  sdo_hold_a: assert property ((!SERIAL_SELECT_LOW && SERIAL_CLK) [*4]
    |-> $stable(SERIAL_OUTPUT_LINE)) else $error("output moved while clock high");
  txv_hold_a: assert property (TX_VALID && !TX_POP |=> TX_VALID && $stable(TX_DATA))
    else $error("word lost without pop");
  txv_idle_a: assert property ((SERIAL_SELECT_LOW && CLK_EN && !TX_VALID) [*8]
    |=> !TX_VALID) else $error("word from nowhere");
  en_freeze_a: assert property (!CLK_EN |=> $stable(TX_DATA) && $stable(GPIO_OUT)
    && $stable(INTERRUPT_OUT_LOW)) else $error("state moved while frozen");
  irq_keep_a: assert property ((SERIAL_SELECT_LOW && !POWER_DOWN_INPUT) [*8]
    |=> !$rose(INTERRUPT_OUT_LOW)) else $error("interrupt cleared without access");
endmodule : txport_chk
bind tx_fifo_serial_host_port txport_chk txport_chk_i (.CORE_CLK, .SYS_RST, .CLK_EN,
  .SERIAL_SELECT_LOW, .SERIAL_CLK, .POWER_DOWN_INPUT, .TX_POP, .SERIAL_OUTPUT_LINE,
  .INTERRUPT_OUT_LOW, .GPIO_OUT, .TX_DATA, .TX_VALID);

// File: verif/serial_host_model.sv
// Purpose: Host side of the four-line serial bus.
// Assumes: Tasks are entered just after a core clock edge.
// Notes:   Serial clock is 8 core cycles, resting low outside frames.
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic clk,
  input  wire logic ser_out,
  output logic      sel_low,
  output logic      sclk,
  output logic      ser_in
);
  // Bus starts deselected with the clock low.
  initial begin
    sel_low = 1'b1;
    sclk = 1'b0;
    ser_in = 1'b0;
  end
  // Select frames a burst; the data line toggles from its previous level.
  task automatic sel(input logic lvl);
    @(posedge clk);
    sel_low <= lvl;
    ser_in <= ~ser_in;
    repeat (8) @(posedge clk);
  endtask : sel
  // Byte MSB first, data moved on the falling clock, read late in the high phase.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ser_in <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rx[i] = ser_out;
      sclk <= 1'b0;
    end
  endtask : xfer
endmodule : serial_host_model

// File: verif/tx_fifo_serial_host_port_test.sv
// Purpose: Self-checking bench for the serial host port.
// Assumes: Host model runs a 200 ns serial clock.
// Notes:   One task per case; POR event input pulses in the gpio and irq cases.
`timescale 1ns/1ps
module tx_fifo_serial_host_port_test import txport_pkg::*;;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       pd_in = 1'b0;
  logic       low_bat = 1'b0;
  logic       wake = 1'b0;
  logic       por = 1'b0;
  logic       tx_pop = 1'b0;
  logic       sel_low, sclk, ser_in, ser_out, irq_low, tx_valid;
  logic [2:0] gpio;
  logic [7:0] tx_data, got;
  int         num_errors = 0;
  int         n_tests = 0;
  tx_fifo_serial_host_port tx_fifo_serial_host_port_i (.CORE_CLK(clk), .SYS_RST(rst),
    .CLK_EN(clk_en), .SERIAL_SELECT_LOW(sel_low), .SERIAL_CLK(sclk),
    .SERIAL_INPUT_LINE(ser_in), .POWER_DOWN_INPUT(pd_in), .POR_EVENT(por),
    .WAKE_EVENT(wake), .LOW_BATTERY(low_bat), .TX_POP(tx_pop), .SERIAL_OUTPUT_LINE(ser_out),
    .INTERRUPT_OUT_LOW(irq_low), .GPIO_OUT(gpio), .TX_DATA(tx_data), .TX_VALID(tx_valid));
  serial_host_model serial_host_model_i (.clk(clk), .ser_out(ser_out), .sel_low(sel_low),
    .sclk(sclk), .ser_in(ser_in));
  // Compares and counts.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  // One framed burst: command then data bytes; last byte read lands in got.
  task automatic acc(input logic [7:0] cmd, input logic [7:0] d[$]);
    logic [7:0] r;
    serial_host_model_i.sel(1'b0);
    serial_host_model_i.xfer(cmd, r);
    foreach (d[k]) serial_host_model_i.xfer(d[k], got);
    serial_host_model_i.sel(1'b1);
  endtask : acc
  task automatic t_regs();
    acc(8'h7D, '{8'h00});
    chk("low_thr", got, 8'h04);
    acc(8'h7C, '{8'h00});
    chk("high_thr", got, RST_TX_HIGH_THR);
    acc(8'hFC, '{8'h11, 8'h22});
    acc(8'h7C, '{8'h00, 8'h00});
    chk("burst", got, 8'h22);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_gpio();
    acc(8'h8B, '{8'h03, 8'h04, 8'h05});
    low_bat <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gpio_on", {5'h0, gpio}, 8'h05);
    low_bat <= 1'b0;
    repeat (4) @(posedge clk);
    chk("gpio_off", {5'h0, gpio}, 8'h04);
    acc(8'h8B, '{8'h01, 8'h02});
    por <= 1'b1;
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gpio_evt", {5'h0, gpio}, 8'h07);
    por <= 1'b0;
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    chk("gpio_quiet", {5'h0, gpio}, 8'h04);
    $display("t_gpio done");
  endtask : t_gpio
  task automatic t_irq();
    acc(8'h04, '{8'h00});
    acc(8'h86, '{8'h08});
    wake <= 1'b1;
    por <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq_masked", {7'h0, irq_low}, 8'h01);
    low_bat <= 1'b1;
    @(posedge clk);
    low_bat <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq_set", {7'h0, irq_low}, 8'h00);
    acc(8'h04, '{8'h00});
    chk("status", got, 8'h58);
    chk("irq_clr", {7'h0, irq_low}, 8'h01);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_fifo();
    logic [7:0] want [3] = '{8'hA5, 8'h5A, 8'h3C};
    acc(8'hFF, '{8'hA5, 8'h5A, 8'h3C});
    clk_en <= 1'b0;
    tx_pop <= 1'b1;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    tx_pop <= 1'b0;
    foreach (want[k]) begin
      for (int w = 0; w < 20 && tx_valid !== 1'b1; w++) @(posedge clk);
      chk("fifo_valid", {7'h0, tx_valid}, 8'h01);
      chk("fifo_word", tx_data, want[k]);
      tx_pop <= 1'b1;
      @(posedge clk);
      tx_pop <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk("fifo_empty", {7'h0, tx_valid}, 8'h00);
    acc(8'h03, '{8'h00});
    chk("status1", got, 8'h50);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_pd();
    pd_in <= 1'b1;
    repeat (6) @(posedge clk);
    pd_in <= 1'b0;
    repeat (6) @(posedge clk);
    acc(8'h7D, '{8'h00});
    chk("pd_thr", got, 8'h04);
    $display("t_pd done");
  endtask : t_pd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Clock, then the sequence of cases, then a watchdog well beyond their length.
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_gpio();
    t_irq();
    t_fifo();
    t_pd();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tx_fifo_serial_host_port_test
